// >>> adc_config_defines.svh
// Constants for the converter configuration register bank.
`ifndef ADC_CONFIG_DEFINES_SVH
`define ADC_CONFIG_DEFINES_SVH

// ---------------------------------------------------------------
// Register addresses
// ---------------------------------------------------------------
`define ADDR_CTRL      8'h00
`define ADDR_DISTORT   8'h02
`define ADDR_FORMAT    8'h3C
`define ADDR_PAT_HIGH  8'h3E
`define ADDR_PAT_LOW   8'h3F
`define ADDR_REFERENCE 8'h44

// ---------------------------------------------------------------
// Serial word layout and timing
// ---------------------------------------------------------------
`define WORD_BITS      16
`define ADDR_BITS      8
`define DATA_BITS      8
`define CNT_BITS       4
`define CNT_ADDR_DONE  4'h7
`define CNT_LAST       4'hF
`define CNT_ZERO       4'h0
`define CNT_ONE        4'h1
`define SYNC_PINS      4
`define SYNC_RESET_VAL 4'hC
`define PIN_SELECT_N   3
`define PIN_SCLK       2
`define PIN_SERIAL_DATA_IN      1
`define PIN_STRAP      0

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CTRL_SOFT_INIT 1
`define CTRL_READBACK  0
`define DIST_BITS      4
`define DIST_HI_MSB    6
`define DIST_HI_LSB    4
`define DIST_LO        0
`define FMT_SRC        7
`define FMT_CHOICE     6
`define PAT_BITS       14
`define PAT_HIGH_LSB   6
`define PAT_LOW_LSB    2
`define REF_SRC        3
`define REF_CHOICE     2

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RST_READBACK   1'b0
`define RST_DISTORT    4'h0
`define RST_FMT_SRC    1'b0
`define RST_FMT_CHOICE 1'b0
`define RST_PATTERN    14'h0000
`define RST_REF_SRC    1'b0
`define RST_REF_CHOICE 1'b0
`define DATA_ZERO      8'h00

`endif

// >>> adc_config_pkg.sv
// Types shared by the configuration register bank.
`include "adc_config_defines.svh"

package adc_config_pkg;

  typedef struct packed {
    logic                    readback;
    logic [`DIST_BITS-1:0]   distort;
    logic                    fmt_src;
    logic                    fmt_choice;
    logic [`PAT_BITS-1:0]    pattern;
    logic                    ref_src;
    logic                    ref_choice;
  } cfg_s;

  typedef struct packed {
    logic [`ADDR_BITS-1:0]   addr;
    logic [`DATA_BITS-1:0]   data;
  } serial_word_s;

  localparam cfg_s CFG_DEFAULT = '{
    readback:   `RST_READBACK,
    distort:    `RST_DISTORT,
    fmt_src:    `RST_FMT_SRC,
    fmt_choice: `RST_FMT_CHOICE,
    pattern:    `RST_PATTERN,
    ref_src:    `RST_REF_SRC,
    ref_choice: `RST_REF_CHOICE
  };

endpackage : adc_config_pkg

// >>> adc_config_register_bank.sv
// Serially programmed configuration register bank of the converter.
//
// Summary of operation
// - Writing one to bit 1 at address 00 restores all defaults, except while readback is selected.
// - Bit 0 at address 00 resets to zero and selects readback.
// - Address 02 bits 6:4 and 0 hold the distortion controls.
// - Bit 7 at 3C picks strap pin (0) or register bit (1).
// - Bit 6 at 3C gives twos complement (0) or offset binary.
// - The format choice bit acts only while its source bit is one.
// - Register 3E bits 7:0 hold pattern bits 13:6.
// - Register 3F bits 7:2 hold pattern bits 5:0.
// - Bit 3 at 44 picks strap pin (0) or register bit (1).
// - Bit 2 at 44 picks internal (0) or external reference.
// - Words of address then data shift in on falling clock edges.
// - In readback only the readback bit is writable and data goes out.
// - The software initialization bit clears itself after use.
`timescale 1ns/1ps

module adc_config_register_bank
  import adc_config_pkg::*;
(
  input  wire logic i_clock,
  input  wire logic i_rstn,
  input  wire logic i_serial_select_n,
  input  wire logic i_serial_clock,
  input  wire logic i_serial_data_in,
  input  wire logic i_format_reference_strap_pin,
  output cfg_s      o_config,
  output logic      o_serial_readback_out,
  output logic      o_output_offset_binary,
  output logic      o_external_reference,
  output logic      o_soft_init_pulse
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [`SYNC_PINS-1:0] pins_raw;
  logic [`SYNC_PINS-1:0] sync_meta_q;
  logic [`SYNC_PINS-1:0] sync_q;
  localparam logic [`SYNC_PINS-1:0] sync_reset_val = `SYNC_RESET_VAL;
  logic                  select_n;
  logic                  sclk;
  logic                  serial_data_in;
  logic                  strap;
  logic                  sclk_prev_q;
  logic                  fall;
  logic [`CNT_BITS-1:0]  bit_cnt_q;
  logic [`WORD_BITS-2:0] shift_q;
  serial_word_s          word;
  logic                  word_done;
  logic                  addr_done;
  logic [`DATA_BITS-1:0] rd_shift_q;
  logic                  soft_init_q;
  cfg_s                  cfg_q;
  logic                  offset_binary_q;
  logic                  external_ref_q;

  // ---------------------------------------------------------------
  // Readback decode
  // ---------------------------------------------------------------
  function automatic logic [`DATA_BITS-1:0] reg_read(
    input logic [`ADDR_BITS-1:0] addr,
    input cfg_s                  cfg
  );
    logic [`DATA_BITS-1:0] value;
    value = `DATA_ZERO;
    case (addr)
      `ADDR_CTRL:
        value[`CTRL_READBACK] = cfg.readback;
      `ADDR_DISTORT:
      begin
        value[`DIST_HI_MSB:`DIST_HI_LSB] =
          cfg.distort[`DIST_BITS-1:1];
        value[`DIST_LO] = cfg.distort[0];
      end
      `ADDR_FORMAT:
      begin
        value[`FMT_SRC]    = cfg.fmt_src;
        value[`FMT_CHOICE] = cfg.fmt_choice;
      end
      `ADDR_PAT_HIGH:
        value = cfg.pattern[`PAT_BITS-1:`PAT_HIGH_LSB];
      `ADDR_PAT_LOW:
        value[`DATA_BITS-1:`PAT_LOW_LSB] =
          cfg.pattern[`PAT_HIGH_LSB-1:0];
      `ADDR_REFERENCE:
      begin
        value[`REF_SRC]    = cfg.ref_src;
        value[`REF_CHOICE] = cfg.ref_choice;
      end
      default:
        value = `DATA_ZERO;
    endcase
    return value;
  endfunction : reg_read

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  assign pins_raw = {i_serial_select_n, i_serial_clock,
                     i_serial_data_in, i_format_reference_strap_pin};

  for (genvar g = 0; g < `SYNC_PINS; g++)
  begin : g_sync
    always_ff @(posedge i_clock or negedge i_rstn)
    begin
      if (!i_rstn)
      begin
        sync_meta_q[g] <= sync_reset_val[g];
        sync_q[g]      <= sync_reset_val[g];
      end
      else
      begin
        sync_meta_q[g] <= pins_raw[g];
        sync_q[g]      <= sync_meta_q[g];
      end
    end
  end

  assign select_n = sync_q[`PIN_SELECT_N];
  assign sclk     = sync_q[`PIN_SCLK];
  assign serial_data_in    = sync_q[`PIN_SERIAL_DATA_IN];
  assign strap    = sync_q[`PIN_STRAP];

  // ---------------------------------------------------------------
  // Serial word assembly
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
      sclk_prev_q <= 1'b1;
    else
      sclk_prev_q <= sclk;
  end

  assign fall      = sclk_prev_q & ~sclk & ~select_n;
  assign word      = {shift_q, serial_data_in};
  assign addr_done = fall & (bit_cnt_q == `CNT_ADDR_DONE);
  assign word_done = fall & (bit_cnt_q == `CNT_LAST);

  // count and shift on falling edges
  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      bit_cnt_q <= `CNT_ZERO;
      shift_q   <= '0;
    end
    else if (select_n)
    begin
      bit_cnt_q <= `CNT_ZERO;
    end
    else if (fall)
    begin
      bit_cnt_q <= bit_cnt_q + `CNT_ONE;
      shift_q   <= word[`WORD_BITS-2:0];
    end
  end

  // ---------------------------------------------------------------
  // Readback shifter
  // ---------------------------------------------------------------
  // addressed byte goes out MSB first
  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
      rd_shift_q <= `DATA_ZERO;
    else if (select_n || !cfg_q.readback)
      rd_shift_q <= `DATA_ZERO;
    else if (addr_done)
      rd_shift_q <= reg_read(word[`ADDR_BITS-1:0], cfg_q);
    else if (word_done)
      rd_shift_q <= `DATA_ZERO;
    else if (fall)
      rd_shift_q <= {rd_shift_q[`DATA_BITS-2:0], 1'b0};
  end

  assign o_serial_readback_out = rd_shift_q[`DATA_BITS-1];

  // ---------------------------------------------------------------
  // Software initialization
  // ---------------------------------------------------------------
  // one-cycle pulse, never held
  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
      soft_init_q <= 1'b0;
    else
      soft_init_q <= word_done & ~cfg_q.readback &
                     (word.addr == `ADDR_CTRL) &
                     word.data[`CTRL_SOFT_INIT];
  end

  assign o_soft_init_pulse = soft_init_q;

  // ---------------------------------------------------------------
  // Register bank
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
      cfg_q <= CFG_DEFAULT;
    else if (soft_init_q)
      cfg_q <= CFG_DEFAULT;
    // readback allows only the readback bit
    else if (word_done && cfg_q.readback)
    begin
      if (word.addr == `ADDR_CTRL)
        cfg_q.readback <= word.data[`CTRL_READBACK];
    end
    else if (word_done)
    begin
      case (word.addr)
        `ADDR_CTRL:
          cfg_q.readback <= word.data[`CTRL_READBACK];
        `ADDR_DISTORT:
          cfg_q.distort <= {word.data[`DIST_HI_MSB:`DIST_HI_LSB],
                            word.data[`DIST_LO]};
        `ADDR_FORMAT:
        begin
          cfg_q.fmt_src    <= word.data[`FMT_SRC];
          cfg_q.fmt_choice <= word.data[`FMT_CHOICE];
        end
        `ADDR_PAT_HIGH:
          cfg_q.pattern[`PAT_BITS-1:`PAT_HIGH_LSB] <= word.data;
        `ADDR_PAT_LOW:
          cfg_q.pattern[`PAT_HIGH_LSB-1:0] <=
            word.data[`DATA_BITS-1:`PAT_LOW_LSB];
        `ADDR_REFERENCE:
        begin
          cfg_q.ref_src    <= word.data[`REF_SRC];
          cfg_q.ref_choice <= word.data[`REF_CHOICE];
        end
        default: ;
      endcase
    end
  end

  assign o_config = cfg_q;

  // ---------------------------------------------------------------
  // Format and reference selection
  // ---------------------------------------------------------------
  // choice one is offset binary
  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
      offset_binary_q <= 1'b0;
    else
      offset_binary_q <= cfg_q.fmt_src ? cfg_q.fmt_choice : strap;
  end

  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
      external_ref_q <= 1'b0;
    else
      external_ref_q <= cfg_q.ref_src ? cfg_q.ref_choice : strap;
  end

  assign o_output_offset_binary = offset_binary_q;
  assign o_external_reference   = external_ref_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);

  a_soft_init_restores: assert property (
    soft_init_q |=> (cfg_q == CFG_DEFAULT) && !soft_init_q)
    else $error("soft init did not restore defaults");
  a_readback_select: assert property (
    word_done && word.addr == `ADDR_CTRL && !word.data[1]
    |=> ##1 cfg_q.readback == $past(word.data[0], 2))
    else $error("readback select not written");
  a_distort_write: assert property (
    word_done && !cfg_q.readback && word.addr == `ADDR_DISTORT
    |=> cfg_q.distort == {$past(word.data[6:4]), $past(word.data[0])})
    else $error("distortion bits wrong");
  a_format_source: assert property (
    cfg_q.fmt_src
    |=> o_output_offset_binary == $past(cfg_q.fmt_choice))
    else $error("format not from register bit");
  a_format_strap: assert property (
    !cfg_q.fmt_src ##1 !cfg_q.fmt_src
    |-> o_output_offset_binary == $past(strap))
    else $error("format not from strap pin");
  a_pattern_word: assert property (
    word_done && !cfg_q.readback && word.addr == `ADDR_PAT_HIGH
    |=> cfg_q.pattern[13:6] == $past(word.data) &&
        $stable(cfg_q.pattern[5:0]))
    else $error("pattern upper bits wrong");
  a_pattern_low: assert property (
    word_done && !cfg_q.readback && word.addr == `ADDR_PAT_LOW
    |=> cfg_q.pattern[5:0] == $past(word.data[7:2]))
    else $error("pattern lower bits wrong");
  a_reference_select: assert property (
    ##1 cfg_q.ref_src ##1 cfg_q.ref_src
    |-> o_external_reference == $past(cfg_q.ref_choice))
    else $error("reference choice ignored");
  a_word_boundary: assert property (
    word_done |=> bit_cnt_q == `CNT_ZERO)
    else $error("bit counter did not wrap at word end");
  a_readback_blocks: assert property (
    word_done && cfg_q.readback && word.addr != `ADDR_CTRL
    |=> $stable(cfg_q) && !soft_init_q)
    else $error("write accepted in readback mode");
  a_readback_first: assert property (
    addr_done && cfg_q.readback
    |=> o_serial_readback_out ==
        $past(reg_read(word[7:0], cfg_q)) >> 7)
    else $error("readback MSB wrong");
  a_soft_init_clears: assert property (
    soft_init_q |=> !soft_init_q [*2])
    else $error("soft init bit held");
  a_unused_zero: assert property (
    addr_done && cfg_q.readback &&
    word[`ADDR_BITS-1:0] == `ADDR_PAT_LOW |=> rd_shift_q[1:0] == 2'h0)
    else $error("unused bits read nonzero");

  c_soft_init: cover property (soft_init_q);
  c_readback_word: cover property (word_done && cfg_q.readback);
  c_pattern_write: cover property (
    word_done && word.addr == `ADDR_PAT_HIGH ##[1:600]
    word_done && word.addr == `ADDR_PAT_LOW);
  c_format_override: cover property (cfg_q.fmt_src && cfg_q.fmt_choice);

endmodule : adc_config_register_bank

// >>> adc_config_register_bank_tb_top.sv
// Self-checking bench for the configuration register bank.
`timescale 1ns/1ps

module adc_config_register_bank_tb_top import adc_config_pkg::*;;
  logic       i_clock, i_rstn, strap, sel_n, sclk, serial_data_in;
  logic       rb_out, offset_bin, ext_ref, init_pulse;
  cfg_s       cfg;
  int         n_errors, checks_done, n_pulses;
  logic [7:0] m [256];
  logic [7:0] rd;
  logic [7:0] addrs [6] = '{8'h02, 8'h3C, 8'h3E, 8'h3F, 8'h44, 8'h55};

  adc_config_register_bank dut (
    .i_clock                      (i_clock),
    .i_rstn                       (i_rstn),
    .i_serial_select_n            (sel_n),
    .i_serial_clock               (sclk),
    .i_serial_data_in             (serial_data_in),
    .i_format_reference_strap_pin (strap),
    .o_config                     (cfg),
    .o_serial_readback_out        (rb_out),
    .o_output_offset_binary       (offset_bin),
    .o_external_reference         (ext_ref),
    .o_soft_init_pulse            (init_pulse)
  );

  adc_serial_controller_model ctl (
    .i_clock    (i_clock),
    .i_readback (rb_out),
    .o_select_n (sel_n),
    .o_sclk     (sclk),
    .o_serial_data_in    (serial_data_in)
  );

  initial
  begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  always @(posedge i_clock)
    if (init_pulse === 1'b1)
      n_pulses++;

  // ---------------------------------------------------------------
  // Reference model and comparison
  // ---------------------------------------------------------------
  function automatic logic [7:0] mask(input logic [7:0] a);
    case (a)
      8'h00:   return 8'h01;
      8'h02:   return 8'h71;
      8'h3C:   return 8'hC0;
      8'h3E:   return 8'hFF;
      8'h3F:   return 8'hFC;
      8'h44:   return 8'h0C;
      default: return 8'h00;
    endcase
  endfunction : mask

  function automatic cfg_s exp_cfg();
    cfg_s c;
    c.readback   = m[8'h00][0];
    c.distort    = {m[8'h02][6:4], m[8'h02][0]};
    c.fmt_src    = m[8'h3C][7];
    c.fmt_choice = m[8'h3C][6];
    c.pattern    = {m[8'h3E], m[8'h3F][7:2]};
    c.ref_src    = m[8'h44][3];
    c.ref_choice = m[8'h44][2];
    return c;
  endfunction : exp_cfg

  task automatic cmp_core(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_core

  task automatic cmp_cfg(input cfg_s got, input cfg_s exp);
    cmp_core({1'b0, got}, {1'b0, exp});
  endtask : cmp_cfg

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_core({16'h0000, got}, {16'h0000, exp});
  endtask : cmp_byte

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_core({23'h00_0000, got}, {23'h00_0000, exp});
  endtask : cmp_bit

  task automatic check_all();
    cmp_cfg(cfg, exp_cfg());
    cmp_bit(offset_bin, m[8'h3C][7] ? m[8'h3C][6] : strap);
    cmp_bit(ext_ref, m[8'h44][3] ? m[8'h44][2] : strap);
    cmp_bit(rb_out, 1'b0);
  endtask : check_all

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ctl.send(a, d, 16, rd);
    if (a == 8'h00 && d[1] && !m[8'h00][0])
      m = '{default: 8'h00};
    else if (!m[8'h00][0] || a == 8'h00)
      m[a] = d & mask(a);
  endtask : wr

  task automatic rdb(input logic [7:0] a);
    logic [7:0] want;
    want = m[a];
    wr(a, 8'($urandom));
    cmp_byte(rd, want);
  endtask : rdb

  task automatic hw_reset();
    i_rstn = 1'b0;
    ctl.tick(16);
    i_rstn = 1'b1;
    m = '{default: 8'h00};
    ctl.tick(8);
  endtask : hw_reset

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  initial
  begin
    repeat (100000) @(posedge i_clock);
    n_errors++;
    end_of_test();
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial
  begin
    i_rstn = 1'b0;
    strap  = 1'b0;
    void'($urandom(32'h6c41_ccd0));
    strap = 1'($urandom);
    hw_reset();
    check_all();
    cmp_bit(init_pulse, 1'b0);
    $display("test reset done");
    repeat (3)
      foreach (addrs[i])
      begin
        wr(addrs[i], 8'($urandom));
        check_all();
      end
    $display("test write done");
    for (int k = 0; k < 8; k++)
    begin
      wr(8'h3C, {k[2:1], 6'h00});
      wr(8'h44, {4'h0, k[2:1], 2'h0});
      strap = k[0];
      ctl.tick(8);
      check_all();
    end
    $display("test select done");
    wr(8'h3E, 8'($urandom));
    ctl.send(8'h3F, 8'($urandom), 11, rd);
    check_all();
    wr(8'h3F, 8'hFF);
    check_all();
    $display("test abort done");
    n_pulses = 0;
    wr(8'h00, 8'h02);
    cmp_byte(n_pulses[7:0], 8'h01);
    check_all();
    wr(8'h3E, 8'hA5);
    wr(8'h00, 8'h03);
    check_all();
    $display("test soft init done");
    wr(8'h3F, 8'($urandom));
    wr(8'h00, 8'h01);
    n_pulses = 0;
    wr(8'h3E, 8'($urandom));
    wr(8'h00, 8'h03);
    cmp_byte(n_pulses[7:0], 8'h00);
    foreach (addrs[i])
      rdb(addrs[i]);
    rdb(8'h00);
    wr(8'h00, 8'h00);
    check_all();
    $display("test readback done");
    wr(8'h02, 8'hFF);
    hw_reset();
    check_all();
    $display("test hardware reset done");
    end_of_test();
  end
endmodule : adc_config_register_bank_tb_top

// >>> adc_serial_controller_model.sv
// Behavioural model of the controller that drives the three-wire port.
`timescale 1ns/1ps

module adc_serial_controller_model
(
  input  wire logic i_clock,
  input  wire logic i_readback,
  output logic      o_select_n,
  output logic      o_sclk,
  output logic      o_serial_data_in
);
  initial
  begin
    o_select_n = 1'b1;
    o_sclk     = 1'b1;
    o_serial_data_in    = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : tick

  // ---------------------------------------------------------------
  // Word transfer
  // ---------------------------------------------------------------
  // address then data MSB first, nbits falling edges.
  task automatic send(input logic [7:0] a, input logic [7:0] d,
                      input int nbits, output logic [7:0] rd);
    logic [15:0] w;
    w  = {a, d};
    rd = 8'h00;
    tick(1);
    o_select_n = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      tick(4);
      o_serial_data_in = w[15 - i];
      tick(4);
      if (i >= 8)
        rd = {rd[6:0], i_readback};
      o_sclk = 1'b0;
      tick(8);
      o_sclk = 1'b1;
    end
    tick(8);
    o_select_n = 1'b1;
    // A released data line must not keep showing its last bit.
    o_serial_data_in = ~o_serial_data_in;
    tick(16);
  endtask : send
endmodule : adc_serial_controller_model
